// [rtl/plcl_cluster.sv]
// one product-term logic cluster with apb configuration port
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module plcl_cluster #(
	parameter int IO_W = 8,
	parameter int EXT_W = 4,
	parameter int NUM_OE = 6,
	parameter int NUM_MC = 256
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire plcl_pkg::plcl_apb_req_t apb_req,
	output plcl_pkg::plcl_apb_rsp_t apb_rsp,
	input wire logic [plcl_pkg::NUM_DED-1:0] ded_in,
	input wire logic [IO_W-1:0] io_in,
	input wire logic [EXT_W-1:0] ext_mc_in,
	output logic [plcl_pkg::MC_PER_CLUSTER-1:0] mc_out,
	output logic [NUM_OE-1:0] oe_out
);
	import plcl_pkg::*;
	localparam int GRM_W = NUM_DED + IO_W + MC_PER_CLUSTER + EXT_W;

	// ==========================================================
	// elaboration checks
	if (NUM_MC % MC_PER_CLUSTER != 0 || NUM_MC == 0) begin : g_bad_mc // R1
		$error("macrocell total must be a multiple of the cluster size");
	end
	if (NUM_OE != 6 && NUM_OE != 10) begin : g_bad_oe // R5
		$error("output enable count must be six or ten");
	end
	if (IO_W < 1 || IO_W > 8 || GRM_W > 32) begin : g_bad_w
		$error("io or routing width out of range");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [31:0] ctrl;
		logic [MAX_OE-1:0][5:0] oe_cfg;
		logic [MC_PER_CLUSTER-1:0][MC_CFG_W-1:0] mc_cfg;
		logic [CLUSTER_INS-1:0][31:0] route;
		logic [TERM_SLOTS-1:0][95:0] term;
		logic [MC_PER_CLUSTER-1:0] q;
		logic [MC_PER_CLUSTER-1:0] clk_prev;
		logic [MAX_OE-1:0] oe;
		logic [31:0] prdata;
		logic pslverr;
	} plcl_state_t;

	plcl_state_t st_r;
	plcl_state_t st_nxt;

	logic run;
	logic [GRM_W-1:0] grm;
	logic [CLUSTER_INS-1:0] cin;
	logic [LIT_W-1:0] lits;
	logic [MC_PER_CLUSTER-1:0] shx;
	logic [MC_PER_CLUSTER-1:0][PT_PER_MC-1:0] pt;
	logic [MC_PER_CLUSTER-1:0] own;
	logic [MC_PER_CLUSTER-1:0] lend_eff;
	logic [MC_PER_CLUSTER-1:0] sum;
	logic [MC_PER_CLUSTER-1:0] d_v;
	logic [MC_PER_CLUSTER-1:0] pwr_v;
	logic [MC_PER_CLUSTER-1:0][1:0] sets_v;
	logic [1:0] g_clk;
	logic setup;
	logic access;
	logic [32:0] rd;
	logic wr_ok;

	// ==========================================================
	// functions
	function automatic logic pterm(input logic [LIT_W-1:0] l,
		input logic [LIT_W-1:0] m);
		pterm = &(l | ~m);
	endfunction : pterm

	// valid, entry, word of the term-mask window
	function automatic logic [9:0] term_loc(input logic [11:0] a);
		logic [11:0] off;
		off = a - OFS_TERM_BASE;
		term_loc = {(a >= OFS_TERM_BASE) && (off[11:4] < 8'd80)
			&& (off[3:2] != 2'h3), off[10:4], off[3:2]};
	endfunction : term_loc

	// valid and word index of a table region
	function automatic logic [6:0] tab_loc(input logic [11:0] a,
		input logic [11:0] base, input logic [6:0] cnt);
		logic [11:0] off;
		off = a - base;
		tab_loc = {(a >= base) && (off[11:2] < {3'h0, cnt}), off[7:2]};
	endfunction : tab_loc

	function automatic logic [32:0] reg_read(input logic [11:0] a,
		input plcl_state_t s, input logic [31:0] sets);
		logic [9:0] t;
		logic [6:0] o;
		logic [6:0] m;
		logic [6:0] r;
		t = term_loc(a);
		o = tab_loc(a, OFS_OE_BASE, 7'(NUM_OE));
		m = tab_loc(a, OFS_MC_BASE, 7'(MC_PER_CLUSTER));
		r = tab_loc(a, OFS_ROUTE_BASE, 7'(CLUSTER_INS));
		reg_read = {1'b0, 32'h0000_0000};
		if (a == OFS_CTRL)
			reg_read = {1'b1, 29'h0, s.ctrl[2:0]};
		else if (a == OFS_STATUS)
			reg_read = {1'b1, 16'h0000, s.q};
		else if (a == OFS_SETS)
			reg_read = {1'b1, sets};
		else if (o[6])
			reg_read = {1'b1, 26'h0, s.oe_cfg[o[3:0]]};
		else if (m[6])
			reg_read = {1'b1, 14'h0, s.mc_cfg[m[3:0]]};
		else if (r[6])
			reg_read = {1'b1, s.route[r[5:0]] & 32'((64'h1 << GRM_W) - 1)};
		else if (t[9]) begin
			reg_read = {1'b1, s.term[t[8:2]][{t[1:0], 5'h00} +: 32]};
			if (t[1:0] == 2'h2)
				reg_read[31:24] = 8'h00;
		end
	endfunction : reg_read

	// ==========================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		run = st_r.ctrl[C_RUN];
		// routing matrix sees every dedicated, pin and macrocell signal
		grm = {ext_mc_in, st_r.q, io_in, ded_in}; // R13
		for (int i = 0; i < CLUSTER_INS; i++) begin
			// one config and-gate per candidate signal
			cin[i] = |(grm & st_r.route[i][GRM_W-1:0]); // R6 R14
		end
		lits = {16'h0000, ~cin, cin};
		// term 0 never sees shareable literals, so no loop forms
		for (int m = 0; m < MC_PER_CLUSTER; m++) begin
			pt[m][0] = pterm(lits,
				{16'h0000, st_r.term[m * PT_PER_MC][71:0]});
			shx[m] = st_r.mc_cfg[m][F_SHARE] & ~pt[m][0]; // R3
		end
		lits[LIT_W-1:2*CLUSTER_INS] = shx;
		for (int m = 0; m < MC_PER_CLUSTER; m++) begin
			for (int t = 1; t < PT_PER_MC; t++) begin
				pt[m][t] = pterm(lits, st_r.term[m * PT_PER_MC + t][LIT_W-1:0]); // R2
			end
			// terms taken for control or sharing leave the sum
			own[m] = (pt[m][0] & ~st_r.mc_cfg[m][F_SHARE])
				| (pt[m][1] & (st_r.mc_cfg[m][F_CLK+:2] != CLK_ARRAY))
				| (pt[m][2] & ~st_r.mc_cfg[m][F_ENA])
				| (pt[m][3] & (st_r.mc_cfg[m][F_CLR+:2] != CLR_PT))
				| (pt[m][4] & ~st_r.mc_cfg[m][F_PRE]); // R2
			lend_eff[m] = st_r.mc_cfg[m][F_LEND]
				& ((m % CHAIN_LEN) != CHAIN_LEN - 1); // R12
			pwr_v[m] = st_r.mc_cfg[m][F_PWRUP];
		end
		for (int m = 0; m < MC_PER_CLUSTER; m++) begin
			logic avail;
			logic borrowed;
			logic [1:0] nsets;
			avail = 1'b1;
			borrowed = 1'b0;
			nsets = 2'h0;
			// at most three contiguous lenders below, same chain only
			for (int k = 1; k <= MAX_SETS; k++) begin // R9
				// wrapped index stays legal where the guard is false
				if (avail && k <= int'(st_r.mc_cfg[m][F_BORROW+:2])
					&& k <= (m % CHAIN_LEN)
					&& lend_eff[(m - k) & (MC_PER_CLUSTER - 1)]) begin // R10 R11
					borrowed = borrowed | own[(m - k) & (MC_PER_CLUSTER - 1)];
					nsets = nsets + 2'h1;
				end else begin
					avail = 1'b0;
				end
			end
			sets_v[m] = nsets; // R9
			// up to five own plus fifteen borrowed terms
			sum[m] = (own[m] & ~lend_eff[m]) | borrowed; // R8
			d_v[m] = st_r.mc_cfg[m][F_INV] ? ~sum[m] : sum[m];
		end
		g_clk[0] = ded_in[DED_GCLK0] ^ st_r.ctrl[C_CKINV]; // R17
		g_clk[1] = ded_in[DED_GOE1] ^ st_r.ctrl[C_CKINV + 1]; // R17
		for (int m = 0; m < MC_PER_CLUSTER; m++) begin
			logic src;
			logic ena;
			logic clr;
			logic pre;
			logic din;
			// safe defaults, the cases below override them
			src = 1'b0;
			clr = 1'b0;
			case (st_r.mc_cfg[m][F_CLK+:2])
				CLK_G0: src = g_clk[0];
				CLK_G1: src = g_clk[1];
				CLK_ARRAY: src = pt[m][1];
				default: src = g_clk[0];
			endcase
			ena = st_r.mc_cfg[m][F_ENA] ? pt[m][2] : 1'b1;
			case (st_r.mc_cfg[m][F_CLR+:2])
				CLR_GLB: clr = ~ded_in[DED_GCLRN]; // R4
				CLR_PT: clr = pt[m][3];
				default: clr = 1'b0;
			endcase
			pre = st_r.mc_cfg[m][F_PRE] & pt[m][4];
			// fast pin path skips the routing matrix
			din = st_r.mc_cfg[m][F_FAST]
				? io_in[st_r.mc_cfg[m][F_FIDX+:3]] : d_v[m]; // R7
			st_nxt.clk_prev[m] = src;
			// low-power flag is kept but alters nothing here
			if (!run)
				st_nxt.q[m] = pwr_v[m]; // R16
			else if (st_r.mc_cfg[m][F_COMB])
				st_nxt.q[m] = din; // R15
			else if (clr)
				st_nxt.q[m] = 1'b0; // R2
			else if (pre)
				st_nxt.q[m] = 1'b1; // R2
			else if (src && !st_r.clk_prev[m] && ena)
				st_nxt.q[m] = din; // R2
		end
		for (int k = 0; k < MAX_OE; k++) begin
			logic pin;
			pin = st_r.oe_cfg[k][F_OE_PIN] ? ded_in[DED_GOE1] : ded_in[DED_GOE0];
			st_nxt.oe[k] = (k < NUM_OE) && run && (st_r.oe_cfg[k][F_OE_LOGIC]
				? st_r.q[st_r.oe_cfg[k][F_OE_MC+:4]] : pin); // R5
		end
		// apb slave: answer prepared in setup, zero wait states
		setup = apb_req.psel & ~apb_req.penable;
		access = apb_req.psel & apb_req.penable;
		rd = reg_read(apb_req.paddr, st_r, sets_v);
		// while running only the control word takes writes
		wr_ok = rd[32] && apb_req.paddr != OFS_STATUS
			&& apb_req.paddr != OFS_SETS
			&& (!run || apb_req.paddr == OFS_CTRL); // R18
		if (setup) begin
			st_nxt.prdata = apb_req.pwrite ? 32'h0000_0000 : rd[31:0];
			st_nxt.pslverr = apb_req.pwrite ? !wr_ok : !rd[32];
		end
		if (access && apb_req.pwrite && wr_ok) begin
			logic [9:0] t;
			logic [6:0] o;
			logic [6:0] mi;
			logic [6:0] r;
			t = term_loc(apb_req.paddr);
			o = tab_loc(apb_req.paddr, OFS_OE_BASE, 7'(NUM_OE));
			mi = tab_loc(apb_req.paddr, OFS_MC_BASE, 7'(MC_PER_CLUSTER));
			r = tab_loc(apb_req.paddr, OFS_ROUTE_BASE, 7'(CLUSTER_INS));
			if (apb_req.paddr == OFS_CTRL)
				st_nxt.ctrl = {29'h0, apb_req.pwdata[2:0]};
			else if (o[6])
				st_nxt.oe_cfg[o[3:0]] = apb_req.pwdata[5:0];
			else if (mi[6])
				st_nxt.mc_cfg[mi[3:0]] = apb_req.pwdata[MC_CFG_W-1:0];
			else if (r[6])
				st_nxt.route[r[5:0]] = apb_req.pwdata;
			else if (t[9])
				st_nxt.term[t[8:2]][{t[1:0], 5'h00} +: 32] = apb_req.pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.ctrl <= RST_CTRL;
			st_r.mc_cfg <= {MC_PER_CLUSTER{RST_MC}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mc_out = st_r.q;
	assign oe_out = st_r.oe[NUM_OE-1:0];
	assign apb_rsp = '{pready: 1'b1, pslverr: st_r.pslverr,
		prdata: st_r.prdata};

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_PWRUP_HOLD: assert property ( // R16
		!run |=> (!$past(run) -> st_r.q == $past(pwr_v)))
		else $error("register left its power-up level while stopped");
	AST_CFG_LOCK: assert property ( // R18
		run && access && apb_req.pwrite && apb_req.paddr != OFS_CTRL
		|=> $stable(st_r.mc_cfg) && $stable(st_r.term) && $stable(st_r.route))
		else $error("configuration changed while running");
	AST_LOCK_ERR: assert property ( // R18
		run && setup && apb_req.pwrite && apb_req.paddr == OFS_MC_BASE
		##1 access |-> apb_rsp.pslverr)
		else $error("locked write not refused");
	AST_CHAIN_ENDS: assert property ( // R12
		!lend_eff[CHAIN_LEN-1] && !lend_eff[MC_PER_CLUSTER-1]
		&& sets_v[0] == 2'h0)
		else $error("chain end lends or chain head borrows");
	AST_CHAIN_SPLIT: assert property ( // R10
		sets_v[CHAIN_LEN] == 2'h0)
		else $error("terms crossed between the two chains");
	AST_BORROW_CONTIG: assert property ( // R11
		sets_v[3] != 2'h0 |-> lend_eff[2] && (sets_v[3] < 2'h2 || lend_eff[1]))
		else $error("borrow skipped a macrocell");
	AST_ROUTE_GATE: assert property ( // R14
		st_r.route[0] == 32'h0000_0000 |-> !cin[0])
		else $error("unselected routing signal entered cluster");
	AST_LOWPWR_COMB: assert property ( // R15
		run && st_r.mc_cfg[0][F_COMB] && st_r.mc_cfg[0][F_LOWPWR]
		&& !st_r.mc_cfg[0][F_FAST] |=> mc_out[0] == $past(d_v[0]))
		else $error("low-power macrocell changed its function");
	AST_GCLR: assert property ( // R4
		run && !st_r.mc_cfg[0][F_COMB] && st_r.mc_cfg[0][F_CLR+:2] == CLR_GLB
		&& !ded_in[DED_GCLRN] |=> !mc_out[0])
		else $error("global clear did not clear the register");
	AST_GCLK_INV: assert property ( // R17
		run && $stable(st_r.mc_cfg[1]) && st_r.ctrl[C_CKINV]
		&& st_r.mc_cfg[1][F_CLK+:2] == CLK_G0 && st_r.mc_cfg[1][6:2] == 5'h00
		&& !st_r.mc_cfg[1][F_FAST] && !ded_in[DED_GCLK0]
		&& $past(ded_in[DED_GCLK0]) && $past(run)
		|=> mc_out[1] == $past(d_v[1]))
		else $error("inverted global clock edge missed");
	AST_OE_PIN: assert property ( // R5
		run && !st_r.oe_cfg[0][F_OE_LOGIC] && !st_r.oe_cfg[0][F_OE_PIN]
		|=> oe_out[0] == $past(ded_in[DED_GOE0]))
		else $error("output enable not taken from its pin");
	// a stopped cluster must never enable an output
	AST_OE_STOPPED: assert property ( // R5
		!run |=> oe_out == '0)
		else $error("output enable active while stopped");
	AST_SETS_LIMIT: assert property ( // R9
		sets_v[4] <= st_r.mc_cfg[4][F_BORROW+:2])
		else $error("more expander sets granted than asked for");
	AST_FAST_COMB: assert property ( // R7
		run && st_r.mc_cfg[2][F_COMB] && st_r.mc_cfg[2][F_FAST]
		|=> mc_out[2] == $past(io_in[st_r.mc_cfg[2][F_FIDX+:3]]))
		else $error("fast pin path did not reach the macrocell");

	COV_THREE_SETS: cover property (sets_v[7] == 2'h3);
	COV_FAST_PATH: cover property (run && st_r.mc_cfg[0][F_FAST]);
	COV_LOCKED_WRITE: cover property (access && apb_rsp.pslverr);
	COV_GCLR_LOW: cover property (run && !st_r.mc_cfg[0][F_COMB]
		&& !ded_in[DED_GCLRN]);
	COV_INV_EDGE: cover property (run && st_r.ctrl[C_CKINV] && g_clk[0]
		&& !st_r.clk_prev[1]);
endmodule : plcl_cluster
`default_nettype wire

// [rtl/plcl_pkg.sv]
// constants and carriers of the product-term logic cluster
// Function
// R1 - sixteen macrocells per cluster, total multiple
// R2 - and array, fixed or, configurable register
// R3 - up to thirty-two product terms per macrocell
// R4 - four dedicated inputs: clock, clear, enables
// R5 - six or ten output enables, pin or logic
// R6 - thirty-six routed signals enter each cluster
// R7 - global controls and direct fast pin paths
// R8 - or gate takes up to twenty terms
// R9 - three sets of five, one delay each
// R10 - two separate lending chains of eight
// R11 - borrow only from contiguous lower neighbours
// R12 - chain head only lends, tail only borrows
// R13 - matrix collects inputs, pins and macrocells
// R14 - each routed signal gated by config and
// R15 - low-power option leaves function unchanged
// R16 - configurable power-up level per register
// R17 - two global clocks with optional inversion
// R18 - configuration static while the logic runs
package plcl_pkg;
	// ==========================================================
	// structure
	localparam int MC_PER_CLUSTER = 16;
	localparam int CHAIN_LEN = 8;
	localparam int PT_PER_MC = 5;
	localparam int MAX_SETS = 3;
	localparam int PAR_PT_MAX = 20;
	localparam int MAX_PT = 32;
	localparam int CLUSTER_INS = 36;
	localparam int NUM_DED = 4;
	localparam int NUM_GCLK = 2;
	localparam int MAX_OE = 10;
	localparam int LIT_W = 2 * CLUSTER_INS + MC_PER_CLUSTER;
	localparam int TERM_SLOTS = MC_PER_CLUSTER * PT_PER_MC;
	localparam int MC_CFG_W = 18;
	// ==========================================================
	// dedicated input roles
	localparam int DED_GCLK0 = 0;
	localparam int DED_GCLRN = 1;
	localparam int DED_GOE0 = 2;
	localparam int DED_GOE1 = 3;
	// ==========================================================
	// byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_SETS = 12'h008;
	localparam logic [11:0] OFS_OE_BASE = 12'h040;
	localparam logic [11:0] OFS_MC_BASE = 12'h080;
	localparam logic [11:0] OFS_ROUTE_BASE = 12'h100;
	localparam logic [11:0] OFS_TERM_BASE = 12'h400;
	// ==========================================================
	// fields
	localparam int C_RUN = 0;
	localparam int C_CKINV = 1;
	localparam int F_CLK = 0;
	localparam int F_ENA = 2;
	localparam int F_CLR = 3;
	localparam int F_PRE = 5;
	localparam int F_PWRUP = 6;
	localparam int F_COMB = 7;
	localparam int F_LOWPWR = 8;
	localparam int F_SHARE = 9;
	localparam int F_LEND = 10;
	localparam int F_BORROW = 11;
	localparam int F_FAST = 13;
	localparam int F_FIDX = 14;
	localparam int F_INV = 17;
	localparam int F_OE_MC = 0;
	localparam int F_OE_LOGIC = 4;
	localparam int F_OE_PIN = 5;
	localparam logic [1:0] CLK_G0 = 2'h0;
	localparam logic [1:0] CLK_G1 = 2'h1;
	localparam logic [1:0] CLK_ARRAY = 2'h2;
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_GLB = 2'h1;
	localparam logic [1:0] CLR_PT = 2'h2;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [MC_CFG_W-1:0] RST_MC = 18'h0_0000;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} plcl_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} plcl_apb_rsp_t;
endpackage : plcl_pkg

// [tb/plcl_partner.sv]
// far-side model: pins, dedicated inputs and neighbour cluster outputs
`timescale 1ns/1ps
`default_nettype none
module plcl_partner #(
	parameter int IO_W = 8,
	parameter int EXT_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	output logic [plcl_pkg::NUM_DED-1:0] ded_in,
	output logic [IO_W-1:0] io_in,
	output logic [EXT_W-1:0] ext_mc_in
);
	import plcl_pkg::*;
	// ==========
	// pin activity
	// pins move in the nonblocking update of the edge, so sampling is race free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ded_in <= '0;
			io_in <= '0;
			ext_mc_in <= '0;
		end else if (en) begin
			ded_in <= NUM_DED'($urandom);
			io_in <= IO_W'($urandom);
			ext_mc_in <= EXT_W'($urandom);
		end
	end
endmodule : plcl_partner
`default_nettype wire

// [tb/plcl_cluster_test.sv]
// self-checking bench of the product-term logic cluster
`timescale 1ns/1ps
`default_nettype none
module plcl_cluster_test;
	import plcl_pkg::*;
	// ==========
	// signals
	localparam logic [87:0] ZM = 88'h1 | (88'h1 << 36);
	localparam logic [11:0] UNM [3] = '{12'h00c, 12'h300, 12'hffc};
	localparam int IDX [6] = '{0, 2, 3, 4, 7, 8};
	logic pclk;
	logic presetn;
	logic en;
	plcl_apb_req_t req;
	plcl_apb_rsp_t rsp;
	logic [3:0] ded;
	logic [7:0] io;
	logic [3:0] ext;
	logic [15:0] mco;
	logic [5:0] oe;
	logic [15:0] exp_v;
	logic [31:0] rdv;
	logic err;
	logic [7:0] io_q;
	logic mc0_q;
	logic [3:0] ded_q;
	logic gp;
	int bad_count;
	int cmp_count;
	int cyc;
	int k;
	plcl_cluster plcl_cluster_inst (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .ded_in(ded), .io_in(io),
		.ext_mc_in(ext), .mc_out(mco), .oe_out(oe));
	plcl_partner plcl_partner_inst (.pclk(pclk), .presetn(presetn),
		.en(en), .ded_in(ded), .io_in(io), .ext_mc_in(ext));
	// ==========
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ceiling well above the roughly five hundred cycles the tests need
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	// ==========
	// tasks
	task end_of_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t reg got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_pin(input logic got, input logic exp, input int idx);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t pin %0d got %b exp %b", $time, idx, got, exp);
		end
	endtask : chk_pin
	// request held from setup until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		// no local limit: only the watchdog may end a wait
		do begin
			@(posedge pclk);
		end while (rsp.pready !== 1'b1);
		rdv = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk_reg({31'h0, err}, {31'h0, e});
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0);
		chk_reg(rdv, x);
		chk_reg({31'h0, err}, {31'h0, e});
	endtask : rd
	task term(input int m, input int t, input logic [87:0] mk);
		logic [11:0] a;
		a = OFS_TERM_BASE + 12'(16 * (m * 5 + t));
		wr(a, mk[31:0], 1'b0);
		wr(a + 12'h4, mk[63:32], 1'b0);
		wr(a + 12'h8, {8'h0, mk[87:64]}, 1'b0);
	endtask : term
	// remaining four own terms forced false, only term0 counts
	task mc(input int m, input logic [17:0] cfg, input logic [87:0] t0);
		wr(OFS_MC_BASE + 12'(4 * m), 32'(cfg), 1'b0);
		term(m, 0, t0);
		for (int t = 1; t < 5; t++)
			term(m, t, ZM);
	endtask : mc
	// ==========
	// reference model of the configured cluster
	function automatic logic [15:0] model(input logic b);
		logic [15:0] v;
		v = '0;
		v[0] = b;
		v[2] = ~b;
		v[4] = b;
		v[7] = b;
		return v;
	endfunction : model
	// ==========
	// main sequence
	initial begin
		k = $urandom(32'h9a389523);
		req = '0;
		presetn = 1'b0;
		en = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CTRL, RST_CTRL, 1'b0);
		rd(OFS_MC_BASE + 12'h4, 32'(RST_MC), 1'b0);
		rd(OFS_STATUS, 32'h0, 1'b0);
		for (int i = 0; i < 3; i++)
			rd(UNM[i], 32'h0, 1'b1);
		wr(OFS_STATUS, 32'h1, 1'b1);
		wr(OFS_MC_BASE + 12'h4, 32'h40, 1'b0);
		repeat (2) @(posedge pclk);
		#1 chk_pin(mco[1], 1'b1, 1);
		k = $urandom_range(7, 0);
		wr(OFS_ROUTE_BASE, 32'h10 << k, 1'b0);
		mc(0, 18'h180, 88'h1);
		mc(2, 18'h80, 88'h1 << 36);
		mc(3, 18'h480, 88'h1);
		mc(4, 18'h880, ZM);
		mc(7, 18'h480, 88'h1);
		mc(8, 18'h880, ZM);
		wr(OFS_OE_BASE, 32'h10, 1'b0);
		apb(1'b0, OFS_SETS, 32'h0);
		chk_reg((rdv >> 8) & 32'h3, 32'h1);
		wr(OFS_CTRL, 32'h1, 1'b0);
		wr(OFS_MC_BASE, 32'h0, 1'b1);
		en <= 1'b1;
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 60; i++) begin
			@(posedge pclk);
			io_q = io;
			mc0_q = mco[0];
			exp_v = model(io_q[k]);
			#1;
			foreach (IDX[j])
				chk_pin(mco[IDX[j]], exp_v[IDX[j]], IDX[j]);
			chk_pin(oe[0], mc0_q, 16);
		end
		// second pass: fast pins, global clear, inverted clock, pin enable
		wr(OFS_CTRL, 32'h0, 1'b0);
		wr(OFS_MC_BASE, 32'h2008 | (32'(k) << 14), 1'b0);
		wr(OFS_MC_BASE + 12'h4, 32'h0, 1'b0);
		wr(OFS_MC_BASE + 12'h8, 32'h2080 | (32'(k) << 14), 1'b0);
		wr(OFS_OE_BASE, 32'h0, 1'b0);
		wr(OFS_CTRL, 32'h3, 1'b0);
		// clock seen at the restart edge is still uninverted
		gp = ded[0];
		mc0_q = 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(posedge pclk);
			io_q = io;
			ded_q = ded;
			if (!ded_q[1])
				mc0_q = 1'b0;
			else if (~ded_q[0] && !gp)
				mc0_q = io_q[k];
			gp = ~ded_q[0];
			#1;
			chk_pin(mco[0], mc0_q, 0);
			chk_pin(mco[2], io_q[k], 2);
			chk_pin(oe[0], ded_q[2], 16);
		end
		end_of_test();
	end
endmodule : plcl_cluster_test
`default_nettype wire
